// ==== include/sec_pkg.sv ====
// Purpose: shared constants and types for the serial EEPROM command engine
// Assumes: opcodes arrive most significant bit first; opcode bit 3 is ignored
// Notes: timing counts are derived from the core clock rate
package sec_pkg;
    // Opcodes with bit 3 masked out
    localparam logic [7:0] OP_MASK = 8'hF7;
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
    localparam logic [7:0] OPC_STAT_RD = 8'h05;
    localparam logic [7:0] OPC_STAT_WR = 8'h01;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    // Array geometry
    localparam int ADDR_W_DEF = 10;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    // Status byte layout
    localparam int SB_BUSY = 0;
    localparam int SB_WEN = 1;
    localparam int SB_BP_LO = 2;
    localparam int SB_BP_HI = 3;
    localparam int SB_HPE = 7;
    localparam logic [7:0] SR_FILL = 8'h70;
    localparam logic [7:0] SR_ALL_ONES = 8'hFF;
    // Block-protect codes and reset values
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic HPE_RST = 1'b0;
    // Self-timed write cycle
    localparam int CLK_HZ = 25_000_000;
    localparam int T_WRITE_US = 5000;
    localparam int WRITE_CYC = T_WRITE_US * (CLK_HZ / 1_000_000);
    // Decoded instruction kinds
    typedef enum logic [2:0] {
        OPK_NONE, OPK_SET, OPK_CLR, OPK_STAT_RD, OPK_STAT_WR, OPK_READ, OPK_WRITE
    } sec_op_e;
    // Link-side frame phases
    typedef enum logic [2:0] {PH_OP, PH_AHI, PH_ALO, PH_DATA, PH_DEAD} sec_ph_e;
endpackage

// ==== verilog/sec_eeprom.sv ====
// Purpose: serial EEPROM slave: command engine, status, protection, array
// Assumes: link logic runs on the serial clock; programming on clk
// Notes: chip select must stay high at least 4 clk cycles between frames
//
// Summary of operation
// (RQ1) After select falls, sample input on rising edges; first byte is opcode.
// (RQ2) Returned data changes on each falling serial clock edge.
// (RQ3) All bytes travel most significant bit first.
// (RQ4) Host raises select after the last bit; device then idles unless busy.
// (RQ5) Opcodes 06h/04h set and clear the write latch; bit 3 ignored.
// (RQ6) Status read returns the status byte repeatedly while clocked.
// (RQ7) Status write updates only protect-enable and two block-protect bits.
// (RQ8) Array read streams bytes from an address, wrapping at the top.
// (RQ9) Array write takes a start address and then data bytes.
// (RQ10) Writes wrap inside one 16-byte page; last 16 bytes are kept.
// (RQ11) Address bits above the array size are ignored.
// (RQ12) Unknown opcode keeps output off and does nothing at select rise.
// (RQ13) Incomplete or surplus bits cancel a status or array modification.
// (RQ14) Write latch clears at reset and after clear, status or array write.
// (RQ15) While busy, only status read is accepted.
// (RQ16) Status write needs latch set and no hardware protection.
// (RQ17) Status bits keep old values until the write cycle ends.
// (RQ18) Protect-enable clears only when protect pin is high at the write.
// (RQ19) Protected block never programmed; elsewhere only with latch set.
// (RQ20) Host should check latch and busy before modifying.
// (RQ21) Raising select ends a read at any point.
// (RQ22) Status: busy b0, latch b1, protect b2-b3, enable b7, b4-b6 ones.
// (RQ23) During a write cycle the whole status byte reads ones.
// (RQ24) Protect code selects none, top quarter, top half or all.
// (RQ25) Write cycle starts when select rises after an accepted write.
// (RQ26) Write cycle length is a parameter; busy held throughout.
`timescale 1ns/100ps
module sec_eeprom
    import sec_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clock_pin,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic wp_n,
    output logic serial_out,
    output logic serial_out_oe,
    output logic busy,
    output logic write_latch
);
    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam int PB_W = ADDR_W - PAGE_W;

    // Opcode decode, bit 3 dropped
    function automatic sec_op_e op_decode(input logic [7:0] b);
        case (b & OP_MASK) // RQ5
            OPC_SET_LATCH: op_decode = OPK_SET;
            OPC_CLR_LATCH: op_decode = OPK_CLR;
            OPC_STAT_RD: op_decode = OPK_STAT_RD;
            OPC_STAT_WR: op_decode = OPK_STAT_WR;
            OPC_READ: op_decode = OPK_READ;
            OPC_WRITE: op_decode = OPK_WRITE;
            default: op_decode = OPK_NONE;
        endcase
    endfunction

    // Status byte as seen by the host
    function automatic logic [7:0] stat_byte(input logic bsy, input logic en, input logic [1:0] bp,
                                             input logic we);
        logic [7:0] s;
        s = SR_FILL; // RQ22
        s[SB_HPE] = en;
        s[SB_BP_HI] = bp[1];
        s[SB_BP_LO] = bp[0];
        s[SB_WEN] = we;
        s[SB_BUSY] = 1'b0;
        stat_byte = bsy ? SR_ALL_ONES : s; // RQ23
    endfunction

    // Address lies in the protected block
    function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [1:0] code);
        case (code) // RQ24
            BP_QUARTER: is_prot = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            BP_HALF: is_prot = a[ADDR_W-1];
            BP_ALL: is_prot = 1'b1;
            default: is_prot = 1'b0;
        endcase
    endfunction

    // Storage and core-side status
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [1:0] bp, next_bp;
    logic hpe, next_hpe;
    logic next_busy, next_write_latch;

    // Link-side state
    logic frame_rst;
    sec_ph_e ph, next_ph;
    sec_op_e kind, next_kind;
    logic [2:0] bitn, next_bitn;
    logic [7:0] shf, next_shf, ahi, next_ahi, tx, next_tx;
    logic [ADDR_W-1:0] addr, next_addr;
    sec_op_e req_kind, next_req_kind;
    logic req_ok, next_req_ok;
    logic [7:0] req_dat, next_req_dat;
    logic [7:0] pg [0:PAGE_BYTES-1];
    logic [7:0] next_pg [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pg_mask, next_pg_mask;
    logic [PB_W-1:0] pg_base, next_pg_base;
    logic busy_s1, busy_s2;
    logic next_so, next_oe;
    logic [7:0] byte_in;
    logic [15:0] full_addr;
    logic last;

    // Select ends any frame at once
    assign frame_rst = rst | cs_n; // RQ21
    assign byte_in = {shf[6:0], serial_in}; // RQ3
    assign last = (bitn == 3'h7);
    assign full_addr = {ahi, byte_in};

    // Link command decode and data capture
    always_comb begin
        next_ph = ph;
        next_kind = kind;
        next_bitn = bitn + 3'h1;
        next_shf = byte_in; // RQ1
        next_ahi = ahi;
        next_addr = addr;
        next_tx = tx;
        next_req_kind = req_kind;
        next_req_ok = req_ok;
        next_req_dat = req_dat;
        next_pg = pg;
        next_pg_mask = pg_mask;
        next_pg_base = pg_base;
        if (ph == PH_OP && bitn == 3'h0) begin
            next_req_kind = OPK_NONE;
            next_req_ok = 1'b0;
        end
        case (ph)
            PH_OP: begin
                if (last) begin
                    next_kind = op_decode(byte_in); // RQ1
                    if (busy_s2 && next_kind != OPK_STAT_RD) begin
                        next_kind = OPK_NONE; // RQ15
                    end
                    next_req_kind = next_kind;
                    case (next_kind)
                        OPK_SET, OPK_CLR: begin
                            next_req_ok = 1'b1; // RQ5
                            next_ph = PH_DEAD;
                        end
                        OPK_STAT_RD: begin
                            next_tx = stat_byte(busy_s2, hpe, bp, write_latch); // RQ6
                            next_ph = PH_DATA;
                        end
                        OPK_STAT_WR: next_ph = PH_DATA;
                        OPK_READ: next_ph = PH_AHI;
                        OPK_WRITE: begin
                            next_pg_mask = '0;
                            next_ph = PH_AHI;
                        end
                        default: next_ph = PH_DEAD; // RQ12
                    endcase
                end
            end
            PH_AHI: begin
                if (last) begin
                    next_ahi = byte_in;
                    next_ph = PH_ALO;
                end
            end
            PH_ALO: begin
                if (last) begin
                    next_addr = full_addr[ADDR_W-1:0]; // RQ11
                    next_pg_base = full_addr[ADDR_W-1:PAGE_W]; // RQ9
                    next_tx = mem[full_addr[ADDR_W-1:0]]; // RQ8
                    next_ph = PH_DATA;
                end
            end
            PH_DATA: begin
                case (kind)
                    OPK_STAT_RD: begin
                        if (last) begin
                            next_tx = stat_byte(busy_s2, hpe, bp, write_latch); // RQ6
                        end
                    end
                    OPK_READ: begin
                        if (last) begin
                            next_addr = addr + 1'b1; // RQ8
                            next_tx = mem[next_addr];
                        end
                    end
                    OPK_STAT_WR: begin
                        if (last) begin
                            next_req_dat = byte_in; // RQ7
                            next_req_ok = 1'b1;
                            next_ph = PH_DEAD;
                        end
                    end
                    OPK_WRITE: begin
                        next_req_ok = last; // RQ13
                        if (last) begin
                            next_pg[addr[PAGE_W-1:0]] = byte_in; // RQ10
                            next_pg_mask[addr[PAGE_W-1:0]] = 1'b1;
                            next_addr[PAGE_W-1:0] = addr[PAGE_W-1:0] + 1'b1; // RQ10
                        end
                    end
                    default: next_ph = PH_DEAD;
                endcase
            end
            PH_DEAD: next_req_ok = 1'b0; // RQ13
            default: next_ph = PH_DEAD;
        endcase
    end

    // Per-frame link registers, cleared while deselected
    always_ff @(posedge serial_clock_pin or posedge frame_rst) begin
        if (frame_rst) begin
            ph <= PH_OP;
            kind <= OPK_NONE;
            bitn <= 3'h0;
            shf <= 8'h00;
            ahi <= 8'h00;
            addr <= '0;
            tx <= 8'h00;
        end else begin
            ph <= next_ph;
            kind <= next_kind;
            bitn <= next_bitn;
            shf <= next_shf;
            ahi <= next_ahi;
            addr <= next_addr;
            tx <= next_tx;
        end
    end

    // Request left for the core; held still while select is high
    always_ff @(posedge serial_clock_pin or posedge rst) begin
        if (rst) begin
            req_kind <= OPK_NONE;
            req_ok <= 1'b0;
            req_dat <= 8'h00;
            pg_mask <= '0;
            pg_base <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                pg[i] <= 8'h00;
            end
        end else begin
            req_kind <= next_req_kind;
            req_ok <= next_req_ok;
            req_dat <= next_req_dat;
            pg_mask <= next_pg_mask;
            pg_base <= next_pg_base;
            pg <= next_pg;
        end
    end

    // Busy flag into the serial clock domain
    always_ff @(posedge serial_clock_pin or posedge rst) begin
        if (rst) begin
            busy_s1 <= 1'b0;
            busy_s2 <= 1'b0;
        end else begin
            busy_s1 <= busy;
            busy_s2 <= busy_s1;
        end
    end

    // Output bit select, MSB first
    always_comb begin
        next_so = tx[~bitn]; // RQ3
        next_oe = (ph == PH_DATA) && (kind == OPK_STAT_RD || kind == OPK_READ); // RQ12
    end

    // Output changes on the falling edge
    always_ff @(negedge serial_clock_pin or posedge frame_rst) begin
        if (frame_rst) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out <= next_so; // RQ2
            serial_out_oe <= next_oe;
        end
    end

    // Core side: pin synchronisers and write cycle
    logic cs_s1, cs_s2, cs_s3, wp_s1, wp_s2, cs_rise;
    logic [TW-1:0] timer, next_timer;
    logic pend_stat, next_pend_stat, wp_cap, next_wp_cap;
    logic [1:0] pend_bp, next_pend_bp;
    logic pend_hpe, next_pend_hpe;
    logic [PAGE_BYTES-1:0] we_vec, prot_vec;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            wp_s1 <= wp_n;
            wp_s2 <= wp_s1;
        end
    end

    assign cs_rise = cs_s2 & ~cs_s3; // RQ4

    // Commit decision and write-cycle sequencing
    always_comb begin
        next_busy = busy;
        next_write_latch = write_latch;
        next_timer = timer;
        next_pend_stat = pend_stat;
        next_pend_bp = pend_bp;
        next_pend_hpe = pend_hpe;
        next_wp_cap = wp_cap;
        next_bp = bp;
        next_hpe = hpe;
        if (busy) begin
            if (timer == '0) begin
                next_busy = 1'b0; // RQ26
                if (pend_stat) begin
                    next_bp = pend_bp; // RQ17
                    next_hpe = pend_hpe;
                end
            end else begin
                next_timer = timer - 1'b1;
            end
        end else if (cs_rise && req_ok) begin // RQ12
            case (req_kind)
                OPK_SET: next_write_latch = 1'b1; // RQ5
                OPK_CLR: next_write_latch = 1'b0; // RQ14
                OPK_STAT_WR: begin
                    if (write_latch && !(hpe && !wp_s2)) begin // RQ16
                        next_busy = 1'b1; // RQ25
                        next_timer = TW'(WRITE_CYCLES - 1);
                        next_write_latch = 1'b0; // RQ14
                        next_pend_stat = 1'b1;
                        next_pend_bp = {req_dat[SB_BP_HI], req_dat[SB_BP_LO]}; // RQ7
                        next_pend_hpe = (hpe && !wp_s2) ? 1'b1 : req_dat[SB_HPE]; // RQ18
                        next_wp_cap = wp_s2;
                    end
                end
                OPK_WRITE: begin
                    if (write_latch) begin // RQ19
                        next_busy = 1'b1; // RQ25
                        next_timer = TW'(WRITE_CYCLES - 1);
                        next_write_latch = 1'b0; // RQ14
                        next_pend_stat = 1'b0;
                    end
                end
                default: next_busy = 1'b0;
            endcase
        end
    end

    // Byte enables for the page, protected block masked out
    always_comb begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            prot_vec[i] = is_prot({pg_base, PAGE_W'(i)}, bp);
            we_vec[i] = busy && timer == '0 && !pend_stat && pg_mask[i] && !prot_vec[i]; // RQ19
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            write_latch <= 1'b0; // RQ14
            timer <= '0;
            pend_stat <= 1'b0;
            pend_bp <= BP_RST;
            pend_hpe <= HPE_RST;
            wp_cap <= 1'b1;
            bp <= BP_RST;
            hpe <= HPE_RST;
        end else begin
            busy <= next_busy;
            write_latch <= next_write_latch;
            timer <= next_timer;
            pend_stat <= next_pend_stat;
            pend_bp <= next_pend_bp;
            pend_hpe <= next_pend_hpe;
            wp_cap <= next_wp_cap;
            bp <= next_bp;
            hpe <= next_hpe;
        end
    end

    // Array programming at the end of the cycle
    always_ff @(posedge clk) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (we_vec[i]) begin
                mem[{pg_base, PAGE_W'(i)}] <= pg[i]; // RQ10
            end
        end
    end

    // Core-side checks
    a_busy_span: assert property (@(posedge clk) disable iff (rst) busy && timer != '0 |=> busy) // RQ26
        else $error("write cycle ended early");
    a_latch_busy: assert property (@(posedge clk) disable iff (rst) busy |-> !write_latch) // RQ14
        else $error("latch set during write cycle");
    a_status_hold: assert property (@(posedge clk) disable iff (rst) // RQ17
        busy && timer != '0 |=> $stable(bp) && $stable(hpe))
        else $error("status changed before cycle end");
    a_hpe_clear: assert property (@(posedge clk) disable iff (rst) $fell(hpe) |-> wp_cap) // RQ18
        else $error("enable cleared with protect pin low");
    // Page lies wholly in or out of a block, so its base decides
    a_prot_block: assert property (@(posedge clk) disable iff (rst) we_vec != '0 |-> bp != BP_ALL // RQ19
        && !(bp == BP_HALF && pg_base[PB_W-1]) && !(bp == BP_QUARTER && pg_base[PB_W-1:PB_W-2] == 2'h3))
        else $error("protected byte programmed");
    a_write_start: assert property (@(posedge clk) disable iff (rst) // RQ25
        cs_rise && !busy && req_ok && req_kind == OPK_WRITE && write_latch |=> busy && !write_latch)
        else $error("array write did not start");
    a_latch_set: assert property (@(posedge clk) disable iff (rst) // RQ5
        cs_rise && !busy && req_ok && req_kind == OPK_SET |=> write_latch)
        else $error("latch not set");
    a_hw_refuse: assert property (@(posedge clk) disable iff (rst) // RQ16
        cs_rise && !busy && hpe && !wp_s2 && req_kind == OPK_STAT_WR |=> !busy)
        else $error("status write accepted under protection");

    // Link-side checks
    a_busy_refuse: assert property (@(posedge serial_clock_pin) disable iff (frame_rst) // RQ15
        ph == PH_OP && last && busy_s2 && op_decode(byte_in) != OPK_STAT_RD |=> kind == OPK_NONE)
        else $error("opcode accepted while busy");
    a_bad_op_off: assert property (@(posedge serial_clock_pin) disable iff (frame_rst) // RQ12
        ph == PH_DEAD && kind == OPK_NONE |-> !serial_out_oe)
        else $error("output driven for unknown opcode");
    a_busy_ones: assert property (@(posedge serial_clock_pin) disable iff (frame_rst) // RQ23
        ph == PH_DATA && kind == OPK_STAT_RD && bitn == 3'h0 && $past(busy_s2) |-> tx == SR_ALL_ONES)
        else $error("status not all ones while busy");
endmodule // sec_eeprom

// ==== verif/sec_host.sv ====
// Purpose: host serial master model driving the EEPROM link
// Assumes: mode 0, clock idle low, 12 ns period inside frames only
// Notes: clock stands still between frames; data shows its inverse then
`timescale 1ns/100ps
module sec_host (
    output logic serial_clock_pin,
    output logic cs_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic saw_oe;
    // Idle bus at time zero
    initial begin
        serial_clock_pin = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        saw_oe = 1'b0;
    end
    // Open a frame with the clock low
    task automatic start();
        cs_n = 1'b0;
        saw_oe = 1'b0;
        #20;
    endtask
    // Shift n bits each way, most significant first
    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #6;
            rx[i] = serial_out_oe ? serial_out : ~serial_out; // Released line reads as the inverse
            saw_oe = saw_oe | serial_out_oe;
            serial_clock_pin = 1'b1;
            #6;
            serial_clock_pin = 1'b0;
        end
    endtask
    // Close the frame before any further rising edge
    task automatic stop();
        #6;
        cs_n = 1'b1;
        serial_in = ~serial_in;
        #200;
    endtask
endmodule // sec_host

// ==== verif/spi_eeprom_command_protect_tb.sv ====
// Purpose: self-checking bench for the serial EEPROM command engine
// Assumes: write cycle shortened to 20 clk; default density, 10 address bits
// Notes: a behavioural array and status model predicts every result
`timescale 1ns/100ps
module spi_eeprom_command_protect_tb;
    import sec_pkg::*;
    logic clk, rst, wp_n, sck, cs_n, sdi, sdo, sdo_oe, busy, write_latch;
    logic [7:0] mem [1024];
    logic [1:0] m_bp;
    logic m_hpe, m_wen;
    int n_errors, checks_done, cycles;
    sec_eeprom #(.ADDR_W(10), .WRITE_CYCLES(20)) dut (.clk(clk), .rst(rst), .serial_clock_pin(sck), .cs_n(cs_n),
        .serial_in(sdi), .wp_n(wp_n), .serial_out(sdo), .serial_out_oe(sdo_oe), .busy(busy), .write_latch(write_latch));
    sec_host host (.serial_clock_pin(sck), .cs_n(cs_n), .serial_in(sdi), .serial_out(sdo), .serial_out_oe(sdo_oe));
    // Core clock
    initial clk = 1'b0;
    always #20 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // Compare one value
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Protected block test
    function automatic bit prot(input logic [9:0] a);
        return (m_bp == 2'h3) || (m_bp == 2'h2 && a >= 10'h200) || (m_bp == 2'h1 && a >= 10'h300);
    endfunction
    // Opcode-only frame, bit 3 set at random
    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        host.start();
        host.shift(8, op | {4'h0, 1'($urandom), 3'h0}, rx);
        host.stop();
    endtask
    // Status read, byte taken twice
    task automatic stat(input logic [7:0] exp);
        logic [7:0] rx;
        host.start();
        host.shift(8, OPC_STAT_RD, rx);
        host.shift(8, 8'h00, rx);
        check("status", rx, exp);
        host.shift(8, 8'h00, rx);
        check("status again", rx, exp);
        host.stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
        #1;
        check("busy", {7'h00, busy}, 8'h00);
        check("latch", {7'h00, write_latch}, {7'h00, m_wen});
        stat({m_hpe, 3'h7, m_bp, m_wen, 1'b0});
    endtask
    task automatic set_latch();
        cmd(OPC_SET_LATCH);
        m_wen = 1'b1;
        repeat (3) @(posedge clk);
        check("latch set", {7'h00, write_latch}, 8'h01);
    endtask
    // Array write of n random bytes at a
    task automatic page_write(input logic [15:0] a, input int n);
        logic [7:0] rx, d;
        logic [9:0] wa;
        bit acc;
        acc = m_wen;
        host.start();
        host.shift(8, OPC_WRITE, rx);
        host.shift(8, a[15:8], rx);
        host.shift(8, a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            host.shift(8, d, rx);
            wa = {a[9:4], 4'(a[3:0] + k)};
            if (acc && !prot(wa)) mem[wa] = d;
        end
        host.stop();
        if (acc) begin
            m_wen = 1'b0;
            cmd(OPC_SET_LATCH);
            stat(SR_ALL_ONES);
        end
        wait_idle();
    endtask
    // Status write with nbits data bits
    task automatic stat_write(input logic [7:0] d, input int nbits);
        logic [7:0] rx;
        host.start();
        host.shift(8, OPC_STAT_WR, rx);
        host.shift(nbits, d, rx);
        host.stop();
        if (nbits == 8 && m_wen && !(m_hpe && !wp_n)) begin
            m_bp = d[3:2];
            m_hpe = d[7];
            m_wen = 1'b0;
        end
        wait_idle();
    endtask
    // Sequential read against the model
    task automatic read_check(input logic [15:0] a, input int n);
        logic [7:0] rx;
        host.start();
        host.shift(8, OPC_READ, rx);
        host.shift(8, a[15:8], rx);
        host.shift(8, a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            host.shift(8, 8'h00, rx);
            check("read", rx, mem[10'(a[9:0] + k)]);
        end
        host.stop();
    endtask
    // Main sequence
    initial begin
        logic [7:0] rx;
        logic [15:0] ra;
        rst = 1'b1;
        wp_n = 1'b1;
        m_bp = 2'h0;
        m_hpe = 1'b0;
        m_wen = 1'b0;
        void'($urandom(32'h5dbeb6d7));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        stat(SR_FILL);
        set_latch();
        cmd(OPC_CLR_LATCH);
        m_wen = 1'b0;
        wait_idle();
        set_latch();
        page_write({6'($urandom), 10'h00E}, 18);
        set_latch();
        page_write({6'($urandom), 10'h3F0}, 16);
        read_check({6'($urandom), 10'h3FC}, 20);
        page_write(16'h0005, 2);
        read_check(16'h0000, 16);
        // Unknown opcode leaves output off and state alone
        host.start();
        host.shift(8, 8'h07, rx);
        host.shift(8, 8'h00, rx);
        check("oe", {7'h00, host.saw_oe}, 8'h00);
        host.stop();
        wait_idle();
        set_latch();
        stat_write(8'h84, 8);
        @(posedge clk) #1 wp_n = 1'b0;
        set_latch();
        stat_write(8'h00, 8);
        page_write(16'h03F8, 2);
        read_check(16'h03F0, 16);
        @(posedge clk) #1 wp_n = 1'b1;
        // Latch set, so only the short data byte can cancel it
        set_latch();
        stat_write(8'h00, 7);
        for (int bp = 0; bp < 4; bp++) begin
            set_latch();
            stat_write({6'h00, 2'(bp)} << 2, 8);
            set_latch();
            page_write(16'($urandom), 3);
            // Known pages below half, inside half only, inside quarter
            for (int j = 0; j < 3; j++) begin
                ra = {6'($urandom), (j == 0) ? 6'h00 : (j == 1) ? 6'h2F : 6'h3F, 4'h0};
                set_latch();
                page_write({ra[15:4], 4'($urandom)}, 16);
                read_check(ra, 16);
            end
        end
        report_and_stop();
    end
endmodule // spi_eeprom_command_protect_tb
